/* File: verilog/three_channel_pwm_timer_mode.sv */
// Three channel PWM timer with AXI4-Lite register slave
`default_nettype none
module three_channel_pwm_timer_mode
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // AXI4-Lite write address and data
  input  wire logic [11:0] i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0] i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  // Count sources
  input  wire logic        i_external_count_pin,
  input  wire logic        i_onchip_osc_40m_clock,
  input  wire logic        i_fast_onchip_osc_clock,
  // PWM pins, index 0 is channel B, 1 is C, 2 is D
  output logic [2:0]       o_channel_pin,
  output logic [2:0]       o_channel_pin_oe,
  // Event pulses, index 0 is the period match, 1..3 are B..D
  output logic [3:0]       o_match_pulse,
  output logic             o_overflow_pulse
);

  // ==========================================================
  // State
  logic [7:0]  mode_reg;
  logic [7:0]  ctrl1_reg;
  logic [7:0]  ctrl2_reg;
  logic [15:0] up_counter_reg;
  logic [15:0] period_register_reg;
  logic [15:0] change_point_b_register_reg;
  logic [15:0] change_point_c_register_reg;
  logic [15:0] change_point_d_register_reg;
  logic [9:0]  rd_idx_reg;
  logic [31:0] rdata_next;

  logic        wr_fire;
  logic [9:0]  wr_idx;
  logic        wr_ctrl1;
  logic        wr_mode;
  logic        tick;
  logic        src_tick;
  logic        counter_run_bit;
  logic        buffer_mode_c;
  logic        buffer_mode_d;
  logic        counter_clear_select;
  logic        stop_at_period_select;
  logic [2:0]  polarity;
  logic [2:0]  initial_level;
  logic [2:0]  chan_en;
  logic [15:0] cp [3];
  logic [3:0]  match;
  logic        overflow;

  // Address decode shared by the write and read paths
  function automatic logic is_mapped(input logic [9:0] idx);
    is_mapped = (idx == pwm_timer_pkg::IDX_MODE)    || (idx == pwm_timer_pkg::IDX_CTRL1)  ||
                (idx == pwm_timer_pkg::IDX_COUNTER) || (idx == pwm_timer_pkg::IDX_PERIOD) ||
                (idx == pwm_timer_pkg::IDX_CP_B)    || (idx == pwm_timer_pkg::IDX_CP_C)   ||
                (idx == pwm_timer_pkg::IDX_CP_D)    || (idx == pwm_timer_pkg::IDX_STATUS) ||
                (idx == pwm_timer_pkg::IDX_CTRL2);
  endfunction

  // Byte lane merge for the 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old_val, input logic [31:0] data,
                                           input logic [3:0] strb);
    merge16 = {strb[1] ? data[15:8] : old_val[15:8], strb[0] ? data[7:0] : old_val[7:0]};
  endfunction

  // ==========================================================
  // Field views
  assign counter_run_bit       = mode_reg[pwm_timer_pkg::MODE_RUN_BIT];
  assign buffer_mode_c         = mode_reg[pwm_timer_pkg::MODE_BFC_BIT];
  assign buffer_mode_d         = mode_reg[pwm_timer_pkg::MODE_BFD_BIT];
  assign counter_clear_select  = ctrl1_reg[pwm_timer_pkg::CTRL1_COUNTER_CLEAR_SELECT_BIT];
  assign initial_level         = ctrl1_reg[pwm_timer_pkg::CTRL1_INIT_LSB +: 3];
  assign polarity              = ctrl2_reg[pwm_timer_pkg::CTRL2_POL_LSB +: 3];
  assign stop_at_period_select = ctrl2_reg[pwm_timer_pkg::CTRL2_STOP_AT_PERIOD_SELECT_BIT];
  // Buffered registers stop driving their own pin
  assign chan_en = mode_reg[pwm_timer_pkg::MODE_EN_LSB +: 3] & {~buffer_mode_d, ~buffer_mode_c, 1'b1};
  assign cp[0] = change_point_b_register_reg;
  assign cp[1] = change_point_c_register_reg;
  assign cp[2] = change_point_d_register_reg;

  // ==========================================================
  // AXI4-Lite write path: address and data are taken in the same cycle
  assign wr_fire  = o_s_axi_awready;
  assign wr_idx   = i_s_axi_awaddr[11:2];
  assign wr_ctrl1 = wr_fire && i_s_axi_wstrb[0] && (wr_idx == pwm_timer_pkg::IDX_CTRL1);
  assign wr_mode  = wr_fire && i_s_axi_wstrb[0] && (wr_idx == pwm_timer_pkg::IDX_MODE);

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready  <= 1'b0;
    end
    else
    begin
      o_s_axi_awready <= i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_awready && !o_s_axi_bvalid;
      o_s_axi_wready  <= i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_awready && !o_s_axi_bvalid;
    end
  end

  // Write response, error for unmapped addresses
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= pwm_timer_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      o_s_axi_bvalid <= 1'b1;
      o_s_axi_bresp  <= is_mapped(wr_idx) ? pwm_timer_pkg::RESP_OKAY : pwm_timer_pkg::RESP_SLVERR;
    end
    else if (i_s_axi_bready)
      o_s_axi_bvalid <= 1'b0;
  end

  // ==========================================================
  // Control registers; a software write to run wins over the hardware stop
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      mode_reg <= pwm_timer_pkg::MODE_RESET;
    else if (wr_mode)
      mode_reg <= i_s_axi_wdata[7:0] & pwm_timer_pkg::MODE_STORED;
    else if (tick && match[0] && stop_at_period_select)
      mode_reg[pwm_timer_pkg::MODE_RUN_BIT] <= 1'b0;
  end

  // Channel A bit and trigger field are kept for read back only
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl1_reg <= pwm_timer_pkg::CTRL1_RESET;
      ctrl2_reg <= pwm_timer_pkg::CTRL2_RESET & pwm_timer_pkg::CTRL2_STORED;
    end
    else if (wr_fire && i_s_axi_wstrb[0])
    begin
      if (wr_idx == pwm_timer_pkg::IDX_CTRL1)
        ctrl1_reg <= i_s_axi_wdata[7:0];
      if (wr_idx == pwm_timer_pkg::IDX_CTRL2)
        ctrl2_reg <= i_s_axi_wdata[7:0] & pwm_timer_pkg::CTRL2_STORED;
    end
  end

  // ==========================================================
  // Count source prescaler
  count_source_sel u_src
  (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_src_sel   (ctrl1_reg[pwm_timer_pkg::CTRL1_SRC_LSB +: 3]),
    .i_ext_count (i_external_count_pin),
    .i_osc40m    (i_onchip_osc_40m_clock),
    .i_fast_osc  (i_fast_onchip_osc_clock),
    .o_tick      (src_tick)
  );

  // Compare matches are judged on the value the tick moves away from
  assign tick     = src_tick && counter_run_bit;
  assign match[0] = up_counter_reg == period_register_reg;
  assign overflow = (up_counter_reg == pwm_timer_pkg::COUNT_MAX) &&
                    !(match[0] && (counter_clear_select || stop_at_period_select));

  generate
    for (genvar g = 0; g < 3; g++)
    begin : g_match
      assign match[g + 1] = up_counter_reg == cp[g];
    end
  endgenerate

  // ==========================================================
  // Up counter; a software write wins over counting
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      up_counter_reg <= pwm_timer_pkg::COUNTER_RESET;
    else if (wr_fire && wr_idx == pwm_timer_pkg::IDX_COUNTER)
      up_counter_reg <= merge16(up_counter_reg, i_s_axi_wdata, i_s_axi_wstrb);
    else if (tick)
    begin
      if (match[0] && stop_at_period_select)
        up_counter_reg <= up_counter_reg;
      else if (match[0] && counter_clear_select)
        up_counter_reg <= 16'h0000;
      else
        up_counter_reg <= up_counter_reg + 16'h0001;
    end
  end

  // General registers with buffer transfer at the period match
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      period_register_reg         <= pwm_timer_pkg::GEN_REG_RESET;
      change_point_b_register_reg <= pwm_timer_pkg::GEN_REG_RESET;
      change_point_c_register_reg <= pwm_timer_pkg::GEN_REG_RESET;
      change_point_d_register_reg <= pwm_timer_pkg::GEN_REG_RESET;
    end
    else
    begin
      if (wr_fire && wr_idx == pwm_timer_pkg::IDX_PERIOD)
        period_register_reg <= merge16(period_register_reg, i_s_axi_wdata, i_s_axi_wstrb);
      else if (tick && match[0] && buffer_mode_c)
        period_register_reg <= change_point_c_register_reg;
      if (wr_fire && wr_idx == pwm_timer_pkg::IDX_CP_B)
        change_point_b_register_reg <= merge16(change_point_b_register_reg, i_s_axi_wdata,
                                               i_s_axi_wstrb);
      else if (tick && match[0] && buffer_mode_d)
        change_point_b_register_reg <= change_point_d_register_reg;
      if (wr_fire && wr_idx == pwm_timer_pkg::IDX_CP_C)
        change_point_c_register_reg <= merge16(change_point_c_register_reg, i_s_axi_wdata,
                                               i_s_axi_wstrb);
      if (wr_fire && wr_idx == pwm_timer_pkg::IDX_CP_D)
        change_point_d_register_reg <= merge16(change_point_d_register_reg, i_s_axi_wdata,
                                               i_s_axi_wstrb);
    end
  end

  // ==========================================================
  // PWM pins; level is stored as pin level so a polarity change waits for an event
  generate
    for (genvar g = 0; g < 3; g++)
    begin : g_pin
      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          o_channel_pin[g] <= 1'b1;
        else if (wr_ctrl1 && chan_en[g])
          o_channel_pin[g] <= i_s_axi_wdata[pwm_timer_pkg::CTRL1_INIT_LSB + g] ?
                              polarity[g] : ~polarity[g];
        else if (tick && chan_en[g] && cp[g] != period_register_reg)
        begin
          if (match[0])
            o_channel_pin[g] <= ~polarity[g];
          else if (match[g + 1])
            o_channel_pin[g] <= polarity[g];
        end
      end
    end
  endgenerate

  // Output enables follow the channel enables
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_channel_pin_oe <= 3'h0;
    else
      o_channel_pin_oe <= chan_en;
  end

  // Event pulses
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_match_pulse    <= 4'h0;
      o_overflow_pulse <= 1'b0;
    end
    else
    begin
      o_match_pulse    <= tick ? match : 4'h0;
      o_overflow_pulse <= tick && overflow;
    end
  end

  // ==========================================================
  // AXI4-Lite read path, one read at a time
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    unique case (i_s_axi_araddr[11:2])
      pwm_timer_pkg::IDX_MODE:    rdata_next[7:0]  = mode_reg;
      pwm_timer_pkg::IDX_CTRL1:   rdata_next[7:0]  = ctrl1_reg;
      pwm_timer_pkg::IDX_CTRL2:   rdata_next[7:0]  = ctrl2_reg | pwm_timer_pkg::CTRL2_ONES;
      pwm_timer_pkg::IDX_COUNTER: rdata_next[15:0] = up_counter_reg;
      pwm_timer_pkg::IDX_PERIOD:  rdata_next[15:0] = period_register_reg;
      pwm_timer_pkg::IDX_CP_B:    rdata_next[15:0] = change_point_b_register_reg;
      pwm_timer_pkg::IDX_CP_C:    rdata_next[15:0] = change_point_c_register_reg;
      pwm_timer_pkg::IDX_CP_D:    rdata_next[15:0] = change_point_d_register_reg;
      pwm_timer_pkg::IDX_STATUS:  rdata_next[5:0]  = {o_channel_pin_oe, o_channel_pin};
      default:                    rdata_next       = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_s_axi_arready <= 1'b0;
    else
      o_s_axi_arready <= i_s_axi_arvalid && !o_s_axi_arready && !o_s_axi_rvalid;
  end

  // Data are captured in the accepting cycle
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata  <= 32'h0000_0000;
      o_s_axi_rresp  <= pwm_timer_pkg::RESP_OKAY;
      rd_idx_reg     <= 10'h000;
    end
    else if (o_s_axi_arready)
    begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata  <= rdata_next;
      rd_idx_reg     <= i_s_axi_araddr[11:2];
      o_s_axi_rresp  <= is_mapped(i_s_axi_araddr[11:2]) ? pwm_timer_pkg::RESP_OKAY :
                        pwm_timer_pkg::RESP_SLVERR;
    end
    else if (i_s_axi_rready)
      o_s_axi_rvalid <= 1'b0;
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_initial_level: assert property (wr_ctrl1 && chan_en[0] |=>
    o_channel_pin[0] == ($past(i_s_axi_wdata[1]) ? polarity[0] : !polarity[0]))
    else $error("pin B not at initial level after control write");
  a_clear_on_period: assert property (tick && match[0] && counter_clear_select &&
    !stop_at_period_select && !wr_fire |=> up_counter_reg == 16'h0000)
    else $error("counter not cleared at period match");
  a_free_running: assert property (tick && !counter_clear_select && !stop_at_period_select &&
    !wr_fire |=> up_counter_reg == $past(up_counter_reg) + 16'h0001)
    else $error("counter did not step by one");
  a_halt_at_period: assert property (tick && match[0] && stop_at_period_select && !wr_fire
    |=> !counter_run_bit && $stable(up_counter_reg))
    else $error("counter did not halt at period match");
  a_stopped_hold: assert property ((!counter_run_bit && !wr_fire) [*2] |->
    $stable(up_counter_reg) && $stable(o_channel_pin))
    else $error("state moved while stopped");
  a_equal_no_change: assert property (tick && chan_en[0] && !wr_ctrl1 &&
    change_point_b_register_reg == period_register_reg |=> $stable(o_channel_pin[0]))
    else $error("pin B changed with change point equal to period");
  a_active_at_change: assert property (tick && chan_en[0] && !wr_ctrl1 && match[1] &&
    !match[0] |=> o_channel_pin[0] == polarity[0])
    else $error("pin B not active after change point");
  a_overflow_pulse: assert property (tick && overflow |=> o_overflow_pulse ##1
    !o_overflow_pulse || $past(tick))
    else $error("overflow pulse missing");
  a_period_buffer: assert property (tick && match[0] && buffer_mode_c && !wr_fire |=>
    period_register_reg == $past(change_point_c_register_reg))
    else $error("buffered period not transferred");
  a_fixed_ones: assert property (o_s_axi_rvalid && rd_idx_reg == pwm_timer_pkg::IDX_CTRL2 |->
    o_s_axi_rdata[4:3] == 2'b11)
    else $error("control 2 unassigned bits not read as one");
  a_bresp_order: assert property (wr_fire |=> o_s_axi_bvalid ##0 !o_s_axi_awready)
    else $error("write response missing");

  c_period_clear: cover property (tick && match[0] && counter_clear_select);
  c_pin_active:   cover property (tick && match[1] && chan_en[0]);
  c_halt:         cover property (tick && match[0] && stop_at_period_select);
  c_overflow:     cover property (o_overflow_pulse);

endmodule
`default_nettype wire

/* File: verilog/pwm_timer_pkg.sv */
// Constants shared by the three channel PWM timer design files
`default_nettype none
package pwm_timer_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [9:0] IDX_MODE     = 10'h120;
  localparam logic [9:0] IDX_CTRL1    = 10'h121;
  localparam logic [9:0] IDX_COUNTER  = 10'h122;
  localparam logic [9:0] IDX_PERIOD   = 10'h124;
  localparam logic [9:0] IDX_CP_B     = 10'h125;
  localparam logic [9:0] IDX_CP_C     = 10'h126;
  localparam logic [9:0] IDX_CP_D     = 10'h127;
  localparam logic [9:0] IDX_STATUS   = 10'h128;
  localparam logic [9:0] IDX_CTRL2    = 10'h130;

  // ==========================================================
  // Field positions
  localparam int unsigned MODE_RUN_BIT   = 0;
  localparam int unsigned MODE_BFC_BIT   = 1;
  localparam int unsigned MODE_BFD_BIT   = 2;
  localparam int unsigned MODE_EN_LSB    = 3;
  localparam int unsigned CTRL1_CHA_BIT  = 0;
  localparam int unsigned CTRL1_INIT_LSB = 1;
  localparam int unsigned CTRL1_SRC_LSB  = 4;
  localparam int unsigned CTRL1_COUNTER_CLEAR_SELECT_BIT = 7;
  localparam int unsigned CTRL2_POL_LSB  = 0;
  localparam int unsigned CTRL2_STOP_AT_PERIOD_SELECT_BIT = 5;
  localparam int unsigned CTRL2_TRIG_LSB = 6;

  // ==========================================================
  // Reset values and fixed read bits
  localparam logic [7:0]  MODE_RESET     = 8'h00;
  localparam logic [7:0]  CTRL1_RESET    = 8'h00;
  localparam logic [7:0]  CTRL2_RESET    = 8'h18;
  localparam logic [7:0]  CTRL2_ONES     = 8'h18;
  localparam logic [7:0]  CTRL2_STORED   = 8'he7;
  localparam logic [7:0]  MODE_STORED    = 8'h3f;
  localparam logic [15:0] GEN_REG_RESET  = 16'hffff;
  localparam logic [15:0] COUNTER_RESET  = 16'h0000;
  localparam logic [15:0] COUNT_MAX      = 16'hffff;

  // ==========================================================
  // Count source codes and prescaler masks
  localparam logic [2:0] SRC_F1    = 3'h0;
  localparam logic [2:0] SRC_F2    = 3'h1;
  localparam logic [2:0] SRC_F4    = 3'h2;
  localparam logic [2:0] SRC_F8    = 3'h3;
  localparam logic [2:0] SRC_F32   = 3'h4;
  localparam logic [2:0] SRC_EXT   = 3'h5;
  localparam logic [2:0] SRC_OSC40 = 3'h6;
  localparam logic [2:0] SRC_FAST  = 3'h7;
  localparam logic [4:0] DIV2_MASK  = 5'h01;
  localparam logic [4:0] DIV4_MASK  = 5'h03;
  localparam logic [4:0] DIV8_MASK  = 5'h07;
  localparam logic [4:0] DIV32_MASK = 5'h1f;

  // ==========================================================
  // Trigger edge codes, stored only
  localparam logic [1:0] TRIG_OFF  = 2'h0;
  localparam logic [1:0] TRIG_RISE = 2'h1;
  localparam logic [1:0] TRIG_FALL = 2'h2;
  localparam logic [1:0] TRIG_BOTH = 2'h3;

  // ==========================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
`default_nettype wire

/* File: verilog/count_source_sel.sv */
// Count source selector: prescaler and edge detectors giving a count tick
`default_nettype none
module count_source_sel
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Selection and sources
  input  wire logic [2:0] i_src_sel,
  input  wire logic       i_ext_count,
  input  wire logic       i_osc40m,
  input  wire logic       i_fast_osc,
  // Count tick
  output logic            o_tick
);

  logic [4:0] div_reg;
  logic [2:0] prev_reg;
  logic       tick_next;

  // ==========================================================
  // Free running prescaler, all divided rates share it
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      div_reg <= 5'h00;
    else
      div_reg <= div_reg + 5'h01;
  end

  // Previous source levels for rising edge detection
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      prev_reg <= 3'h7;
    else
      prev_reg <= {i_fast_osc, i_osc40m, i_ext_count};
  end

  // Source decode; the fast oscillator is only counted correctly below half the clock
  always_comb
  begin
    unique case (i_src_sel)
      pwm_timer_pkg::SRC_F1:    tick_next = 1'b1;
      pwm_timer_pkg::SRC_F2:    tick_next = (div_reg & pwm_timer_pkg::DIV2_MASK) == pwm_timer_pkg::DIV2_MASK;
      pwm_timer_pkg::SRC_F4:    tick_next = (div_reg & pwm_timer_pkg::DIV4_MASK) == pwm_timer_pkg::DIV4_MASK;
      pwm_timer_pkg::SRC_F8:    tick_next = (div_reg & pwm_timer_pkg::DIV8_MASK) == pwm_timer_pkg::DIV8_MASK;
      pwm_timer_pkg::SRC_F32:   tick_next = div_reg == pwm_timer_pkg::DIV32_MASK;
      pwm_timer_pkg::SRC_EXT:   tick_next = i_ext_count & ~prev_reg[0];
      pwm_timer_pkg::SRC_OSC40: tick_next = i_osc40m & ~prev_reg[1];
      pwm_timer_pkg::SRC_FAST:  tick_next = i_fast_osc & ~prev_reg[2];
    endcase
  end

  // Registered tick, one cycle of latency for every source
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_tick <= 1'b0;
    else
      o_tick <= tick_next;
  end

endmodule
`default_nettype wire

/* File: verif/pwm_load.sv */
// Load model on the three PWM pins, with a pull-up on each pad
`default_nettype none
module pwm_load
(
  // Pins from the timer
  input  wire logic [2:0] i_pin,
  input  wire logic [2:0] i_oe,
  // Pad levels seen by the load
  output logic [2:0]      o_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released pad floats to the pull-up, never to the last driven level
  assign o_level = (i_pin & i_oe) | ~i_oe;
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the three channel PWM timer
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'h0001211b;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, ovf;
  logic [1:0]  bresp, rresp;
  logic [2:0]  pin, oe, lvl;
  logic [3:0]  match;
  logic        ext = 1'b0;
  int          miscompares = 0, checked = 0, cycles = 0, m, n, c, k;
  always #4 i_clk = ~i_clk;
  three_channel_pwm_timer_mode DUT (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_external_count_pin(ext),
    .i_onchip_osc_40m_clock(1'b0), .i_fast_onchip_osc_clock(1'b0), .o_channel_pin(pin),
    .o_channel_pin_oe(oe), .o_match_pulse(match), .o_overflow_pulse(ovf));
  pwm_load load (.i_pin(pin), .i_oe(oe), .o_level(lvl));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked = checked + 1;
    if (s !== e)
    begin
      miscompares = miscompares + 1;
      $display("MISMATCH %0t %h %h", $time, s, e);
    end
  endtask
  task automatic finish_test();
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Write: address and data together, held until taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge i_clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    // Raised only after the handshake so back to back writes never touch it twice
    bready <= 1'b1;
    do @(posedge i_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, 32'h0);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge i_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge i_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, r});
  endtask
  // Hang guard, far above the several hundred cycles the run needs
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles > 8000)
    begin
      miscompares = miscompares + 1;
      finish_test();
    end
  end
  initial
  begin
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    rd_chk(12'h484, 32'h00, 2'h0);
    rd_chk(12'h4c0, 32'h18, 2'h0);
    rd_chk(12'h004, 32'h00, 2'h2);
    wr(12'h4c0, 32'hc7);
    rd_chk(12'h4c0, 32'hdf, 2'h0);
    wr(12'h480, 32'h08);
    // Random period and change point, both polarities
    for (k = 0; k < 3; k++)
    begin
      seed = nxt(seed);
      m = 8 + seed[4:0];
      n = seed[9:5] % m;
      wr(12'h480, 32'h08);
      wr(12'h4c0, {31'h0, k[0]});
      wr(12'h490, m);
      wr(12'h494, n);
      wr(12'h488, 32'h0);
      wr(12'h484, 32'h83);
      @(posedge i_clk);
      chk({31'h0, lvl[0]}, {31'h0, k[0]});
      wr(12'h484, 32'h80);
      @(posedge i_clk);
      chk({31'h0, lvl[0]}, {31'h0, !k[0]});
      wr(12'h480, 32'h09);
      while (lvl[0] !== k[0]) @(posedge i_clk);
      for (c = 0; lvl[0] === k[0]; c++) @(posedge i_clk);
      chk(c, m - n);
      for (c = 0; lvl[0] !== k[0]; c++) @(posedge i_clk);
      chk(c, n + 1);
    end
    // Halt at period match without clearing
    wr(12'h480, 32'h08);
    wr(12'h484, 32'h00);
    wr(12'h4c0, 32'h20);
    wr(12'h488, 32'h0);
    wr(12'h480, 32'h09);
    for (c = 0; match[0] !== 1'b1; c++) @(posedge i_clk);
    chk(c, m + 1);
    repeat (8) @(posedge i_clk);
    rd_chk(12'h488, m, 2'h0);
    rd_chk(12'h480, 32'h08, 2'h0);
    // Free run through overflow; change point equal to period keeps pin B active
    wr(12'h4c0, 32'h00);
    wr(12'h484, 32'h02);
    wr(12'h494, m);
    wr(12'h488, 32'hfff0);
    wr(12'h480, 32'h09);
    for (c = 0; ovf !== 1'b1; c++) @(posedge i_clk);
    chk(c, 32'h10);
    repeat (48) @(posedge i_clk);
    chk({31'h0, lvl[0]}, 32'h0);
    // Buffered period and change point move over at the period match
    wr(12'h480, 32'h08);
    wr(12'h484, 32'h80);
    wr(12'h488, 32'h0);
    wr(12'h498, m + 4);
    wr(12'h49c, n + 1);
    wr(12'h480, 32'h0f);
    repeat (60) @(posedge i_clk);
    rd_chk(12'h490, m + 4, 2'h0);
    rd_chk(12'h494, n + 1, 2'h0);
    // External pin rising edges as count source, fast oscillator never picked
    wr(12'h480, 32'h08);
    wr(12'h484, 32'h50);
    wr(12'h488, 32'h0);
    wr(12'h480, 32'h09);
    repeat (5)
    begin
      ext <= 1'b1;
      @(posedge i_clk);
      ext <= 1'b0;
      @(posedge i_clk);
    end
    wr(12'h480, 32'h08);
    rd_chk(12'h488, 32'h5, 2'h0);
    finish_test();
  end
endmodule
`default_nettype wire
